// [logic/ipv_pkg.sv]
// Constants, register map and carrier types of the interrupt vectoring unit.
// Assumes one APB clock domain and sources on the same clock.
package ipv_pkg;

  localparam int NPER = 30;
  localparam int NDBG = 3;
  localparam int NSRC = NPER + NDBG;
  localparam int AW   = 19;

  // Vector numbering
  localparam logic [6:0] PER_VEC0  = 7'h38;
  localparam logic [6:0] RSV_VEC_A = 7'h46;
  localparam logic [6:0] RSV_VEC_B = 7'h51;
  localparam logic [6:0] DBG_VEC0  = 7'h01;
  localparam logic [6:0] RST_SLOTS = 7'h02;

  localparam logic [AW-1:0] RST_BASE = 19'h00200;
  localparam logic [AW-1:0] VB_RESET = 19'h00000;

  // Register byte offsets
  localparam logic [11:0] OFS_DBG_PRIO = 12'h000;
  localparam logic [11:0] OFS_PRIO_LO  = 12'h004;
  localparam logic [11:0] OFS_PRIO_HI  = 12'h008;
  localparam logic [11:0] OFS_VBASE    = 12'h00C;
  localparam logic [11:0] OFS_PEND_PER = 12'h010;
  localparam logic [11:0] OFS_PEND_DBG = 12'h014;
  localparam logic [11:0] OFS_ACTIVE   = 12'h018;
  localparam logic [11:0] OFS_ISTAT    = 12'h01C;
  localparam logic [11:0] OFS_ICLR     = 12'h020;
  localparam logic [11:0] OFS_IEN      = 12'h024;

  // Debug priority register fields
  localparam int RX_FULL_LSB  = 4;
  localparam int TX_EMPTY_LSB = 2;
  localparam int TRACE_LSB    = 0;
  localparam logic [15:0] DBG_WMASK = 16'h003F;
  localparam logic [1:0]  PRIO_OFF  = 2'h0;

  // Event bits
  localparam int NEV      = 2;
  localparam int EV_NEW   = 0;
  localparam int EV_BLOCK = 1;

  typedef struct packed {
    logic          valid;
    logic [6:0]    vector;
    logic [1:0]    level;
    logic [AW-1:0] entry;
  } vec_out_s;

endpackage

// [logic/prio_pick.sv]
// Combinational winner search over candidate sources.
// Assumes source index order equals vector number order.
`timescale 1ns/10ps
module prio_pick #(
  parameter int N = 4
) (
  input  wire logic [N-1:0]   cand,
  input  wire logic [2*N-1:0] lvl,
  output logic                found,
  output logic [5:0]          idx,
  output logic [1:0]          best
);

  always_comb begin
    found = 1'b0;
    idx   = 6'h00;
    best  = 2'h0;
    // Descending scan with >= leaves the lowest index among equals
    for (int i = N - 1; i >= 0; i--) begin
      if (cand[i] && (!found || lvl[2*i +: 2] >= best)) begin
        found = 1'b1;
        idx   = 6'(i);
        best  = lvl[2*i +: 2];
      end
    end
  end

endmodule

// [logic/irq_vectoring.sv]
// Interrupt priority and vectoring unit with APB register access.
// Assumes request inputs are levels from logic on pclk.
//
// Summary of operation
// - Entry address is base plus twice vector
// - Entry addresses limited to 19 bits
// - Base 0x0200 never delivers vectors 0, 1
// - Peripheral vectors fixed 56..85, skip 70, 81
// - Debug priority bits 15..6 read zero
// - Receive-full priority in bits 5..4
// - Transmit-empty priority in bits 3..2
// - Trace-buffer priority in bits 1..0
// - Debug field 00 off, else levels 1..3
// - Peripheral field 00 off, else levels 0..2
// - Pending reported active low, resets to ones
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/10ps
module irq_vectoring
  import ipv_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  input  wire logic [3:0]      pstrb,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [NPER-1:0] periph_req,
  input  wire logic [NDBG-1:0] dbg_req,
  output vec_out_s             core_vec,
  output logic                 irq
);

  logic [5:0]          dbg_prio_q;
  logic [2*NPER-1:0]   per_prio_q;
  logic [AW-1:0]       vbase_q;
  logic [NSRC-1:0]     pend_q;
  logic [NEV-1:0]      ist_q;
  logic [NEV-1:0]      ien_q;
  logic [31:0]         prdata_q;
  logic                pready_q;
  logic                pslverr_q;
  logic                irq_q;
  vec_out_s            vec_q;
  vec_out_s            vec_d;
  logic                blk_q;

  logic [NSRC-1:0]     elig;
  logic [NSRC-1:0]     req;
  logic [NSRC-1:0]     blk;
  logic [2*NSRC-1:0]   lvl;
  logic [6:0]          vnum [NSRC];
  logic                found;
  logic [5:0]          widx;
  logic [1:0]          wlvl;
  logic                blk_any;
  logic [NEV-1:0]      ev;

  logic                setup;
  logic                acc;
  logic                wr;
  logic                hit;
  logic [31:0]         wmask;
  logic [31:0]         rd_d;

  ////////////////////////////////////////////////////////////////////////////
  // Source table

  assign req = {periph_req, dbg_req};

  for (genvar g = 0; g < NDBG; g++) begin : g_dbg
    localparam int LSB = 2 * (NDBG - 1 - g);
    assign vnum[g] = DBG_VEC0 + 7'(g);
    assign elig[g] = dbg_prio_q[LSB +: 2] != PRIO_OFF;
    assign lvl[2*g +: 2] = dbg_prio_q[LSB +: 2];
    assign blk[g] = (vbase_q == RST_BASE) && (vnum[g] < RST_SLOTS);
  end

  for (genvar p = 0; p < NPER; p++) begin : g_per
    localparam int S = NDBG + p;
    logic [1:0] fld;
    assign fld     = per_prio_q[2*p +: 2];
    assign vnum[S] = PER_VEC0 + 7'(p);
    assign elig[S] = fld != PRIO_OFF && vnum[S] != RSV_VEC_A
                     && vnum[S] != RSV_VEC_B;
    assign lvl[2*S +: 2] = fld - 2'h1;
    assign blk[S] = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= '0;
    end else begin
      pend_q <= req & elig;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration and vector output

  prio_pick #(.N(NSRC)) u_pick (
    .cand  (pend_q & ~blk),
    .lvl   (lvl),
    .found (found),
    .idx   (widx),
    .best  (wlvl)
  );

  always_comb begin
    vec_d        = '0;
    vec_d.valid  = found;
    vec_d.level  = wlvl;
    vec_d.vector = found ? vnum[widx] : 7'h00;
    // two words per entry; 19-bit wrap
    vec_d.entry  = found ? vbase_q + AW'({vnum[widx], 1'b0}) : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_q <= '0;
    end else begin
      vec_q <= vec_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events and interrupt

  assign blk_any = |(pend_q & blk);
  assign ev[EV_NEW]   = vec_d.valid &&
                        (!vec_q.valid || vec_d.vector != vec_q.vector);
  assign ev[EV_BLOCK] = blk_any && !blk_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_q <= 1'b0;
    end else begin
      blk_q <= blk_any;
    end
  end

  // Set beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= '0;
    end else if (wr && paddr == OFS_ICLR) begin
      // Only bits written as one in enabled bytes are cleared
      ist_q <= (ist_q & ~(pwdata[NEV-1:0] & wmask[NEV-1:0])) | ev;
    end else begin
      ist_q <= ist_q | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(ist_q & ien_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  assign setup = psel && !penable;
  assign acc   = psel && penable && pready_q;
  assign wr    = acc && pwrite;
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
                  {8{pstrb[0]}}};

  always_comb begin
    hit  = 1'b1;
    rd_d = 32'h00000000;
    case (paddr)
      OFS_DBG_PRIO: rd_d = {26'h0000000, dbg_prio_q};
      OFS_PRIO_LO:  rd_d = per_prio_q[31:0];
      OFS_PRIO_HI:  rd_d = {4'h0, per_prio_q[2*NPER-1:32]};
      OFS_VBASE:    rd_d = {13'h0000, vbase_q};
      OFS_PEND_PER: rd_d = {2'h3, ~pend_q[NSRC-1:NDBG]};
      OFS_PEND_DBG: rd_d = {29'h1FFFFFFF, ~pend_q[NDBG-1:0]};
      OFS_ACTIVE:   rd_d = {22'h000000, vec_q.valid, vec_q.level,
                            vec_q.vector};
      OFS_ISTAT:    rd_d = {30'h00000000, ist_q};
      OFS_ICLR:     rd_d = 32'h00000000;
      OFS_IEN:      rd_d = {30'h00000000, ien_q};
      default:      hit  = 1'b0;
    endcase
  end

  // One wait-free access: answer prepared in setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !hit;
      prdata_q  <= (setup && !pwrite) ? rd_d : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_prio_q <= '0;
    end else if (wr && paddr == OFS_DBG_PRIO) begin
      dbg_prio_q <= (dbg_prio_q & ~wmask[5:0])
                    | (pwdata[5:0] & wmask[5:0] & DBG_WMASK[5:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_prio_q <= '0;
    end else if (wr && paddr == OFS_PRIO_LO) begin
      per_prio_q[31:0] <= (per_prio_q[31:0] & ~wmask)
                          | (pwdata & wmask);
    end else if (wr && paddr == OFS_PRIO_HI) begin
      per_prio_q[2*NPER-1:32] <=
        (per_prio_q[2*NPER-1:32] & ~wmask[27:0])
        | (pwdata[27:0] & wmask[27:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vbase_q <= VB_RESET;
    end else if (wr && paddr == OFS_VBASE) begin
      vbase_q <= (vbase_q & ~wmask[AW-1:0])
                 | (pwdata[AW-1:0] & wmask[AW-1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_q <= '0;
    end else if (wr && paddr == OFS_IEN) begin
      ien_q <= (ien_q & ~wmask[NEV-1:0]) | (pwdata[NEV-1:0] & wmask[NEV-1:0]);
    end
  end

  assign prdata   = prdata_q;
  assign pready   = pready_q;
  assign pslverr  = pslverr_q;
  assign core_vec = vec_q;
  assign irq      = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_entry_address: assert property (
    vec_q.valid |-> vec_q.entry ==
      AW'($past(vbase_q) + AW'({vec_q.vector, 1'b0})))
    else $error("entry address mismatch");

  a_base_width: assert property (
    wr && paddr == OFS_VBASE |=> vbase_q == $past(pwdata[AW-1:0]))
    else $error("vector base not 19-bit write");

  a_reset_slot: assert property (
    $past(vbase_q) == RST_BASE |-> !(vec_q.valid && vec_q.vector < RST_SLOTS))
    else $error("reset slot delivered");

  a_vector_set: assert property (
    vec_q.valid && vec_q.vector >= PER_VEC0 |->
      vec_q.vector != RSV_VEC_A && vec_q.vector != RSV_VEC_B
      && vec_q.vector <= 7'h55)
    else $error("illegal peripheral vector");

  a_dbg_reserved: assert property (
    setup && !pwrite && paddr == OFS_DBG_PRIO |=> prdata[31:6] == '0)
    else $error("debug reserved bits nonzero");

  a_rx_field: assert property (
    vec_q.valid && vec_q.vector == DBG_VEC0 |->
      vec_q.level == $past(dbg_prio_q[RX_FULL_LSB +: 2]))
    else $error("receive-full level wrong");

  a_tx_field: assert property (
    vec_q.valid && vec_q.vector == DBG_VEC0 + 7'h01 |->
      vec_q.level == $past(dbg_prio_q[TX_EMPTY_LSB +: 2]))
    else $error("transmit-empty level wrong");

  a_trace_field: assert property (
    vec_q.valid && vec_q.vector == DBG_VEC0 + 7'h02 |->
      vec_q.level == $past(dbg_prio_q[TRACE_LSB +: 2]))
    else $error("trace level wrong");

  a_dbg_off: assert property (
    dbg_prio_q[RX_FULL_LSB +: 2] == PRIO_OFF && dbg_req[0] |=> !pend_q[0])
    else $error("disabled debug source pending");

  a_per_level: assert property (
    vec_q.valid && vec_q.vector >= PER_VEC0 |-> vec_q.level != 2'h3)
    else $error("peripheral level above 2");

  a_pending_low: assert property (
    periph_req[0] && per_prio_q[1:0] != PRIO_OFF |=> ##1 !prdata_q[0]
      || !$past(setup, 1) || $past(paddr, 1) != OFS_PEND_PER
      || $past(pwrite, 1))
    else $error("pending bit not low");

  a_winner_best: assert property (
    found && pend_q[0] && !blk[0] |-> wlvl >= lvl[1:0])
    else $error("lower level won");

  c_debug_win: cover property (vec_q.valid && vec_q.vector < PER_VEC0);
  c_periph_win: cover property (vec_q.valid && vec_q.vector >= PER_VEC0);
  c_blocked: cover property (ev[EV_BLOCK]);
  c_irq_raise: cover property (!irq ##1 irq);

endmodule

// [verif/req_src_model.sv]
// Model of the request sources beside the vectoring unit.
// Assumes the bench commands request levels on pclk.
`timescale 1ns/10ps
module req_src_model
  import ipv_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic [NPER-1:0] per_cmd,
  input  wire logic [NDBG-1:0] dbg_cmd,
  output logic      [NPER-1:0] periph_req,
  output logic      [NDBG-1:0] dbg_req
);
  // No acknowledge: sources hold levels until told to drop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_req <= '0;
      dbg_req    <= '0;
    end else begin
      periph_req <= per_cmd;
      dbg_req    <= dbg_cmd;
    end
  end
endmodule

// [verif/irq_vectoring_tb_top.sv]
// Self-checking bench of the interrupt vectoring unit.
// Assumes APB with no wait states and level requests on pclk.
`timescale 1ns/10ps
module irq_vectoring_tb_top
  import ipv_pkg::*;
;
  logic            pclk = 1'b0;
  logic            presetn = 1'b0;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [11:0]     paddr = '0;
  logic [31:0]     pwdata = '0;
  logic [3:0]      pstrb = 4'hF;
  logic [31:0]     prdata;
  logic [31:0]     rd;
  logic            pready;
  logic            pslverr;
  logic            er;
  logic            irq;
  logic [NPER-1:0] per_cmd = '0;
  logic [NDBG-1:0] dbg_cmd = '0;
  logic [NPER-1:0] periph_req;
  logic [NDBG-1:0] dbg_req;
  vec_out_s        core_vec;
  int              miscompares = 0;
  int              checks = 0;

  always #10 pclk = ~pclk;

  irq_vectoring irq_vectoring_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph_req(periph_req), .dbg_req(dbg_req),
    .core_vec(core_vec), .irq(irq));

  req_src_model req_src_model_i (.pclk(pclk), .presetn(presetn),
    .per_cmd(per_cmd), .dbg_cmd(dbg_cmd), .periph_req(periph_req),
    .dbg_req(dbg_req));

  ////////////////////////////////////////
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk("prdata", e, rd);
  endtask

  // Irq lands one edge after the vector; checks read pre-edge values
  task automatic settle;
    repeat (5) @(posedge pclk);
  endtask

  // Expected vector built from base plus two words per vector
  task automatic vchk(input logic [6:0] v, input logic [1:0] l,
                      input logic [AW-1:0] b);
    vec_out_s e;
    e.valid  = 1'b1;
    e.vector = v;
    e.level  = l;
    e.entry  = b + {v, 1'b0};
    chk("core_vec", 32'(e), 32'(core_vec));
  endtask

  ////////////////////////////////////////
  task automatic t_reset;
    chk("core_vec", '0, 32'(core_vec));
    chk("irq", '0, 32'(irq));
    rchk(OFS_DBG_PRIO, '0);
    rchk(OFS_PRIO_LO, '0);
    rchk(OFS_PEND_PER, 32'hFFFFFFFF);
    rchk(OFS_PEND_DBG, 32'hFFFFFFFF);
  endtask

  task automatic t_dbg;
    apb(1'b1, OFS_DBG_PRIO, 32'hFFFFFFFF);
    rchk(OFS_DBG_PRIO, 32'h0000003F);
    apb(1'b1, OFS_DBG_PRIO, 32'h00000024);
    dbg_cmd <= 3'h7;
    settle();
    vchk(7'h01, 2'h2, '0);
    rchk(OFS_PEND_DBG, 32'hFFFFFFFC);
    apb(1'b1, OFS_DBG_PRIO, 32'h0000000B);
    settle();
    vchk(7'h03, 2'h3, '0);
    apb(1'b1, OFS_DBG_PRIO, 32'h00000008);
    settle();
    vchk(7'h02, 2'h2, '0);
    dbg_cmd <= '0;
    apb(1'b1, OFS_DBG_PRIO, '0);
  endtask

  task automatic t_per;
    apb(1'b1, OFS_VBASE, 32'h00000100);
    apb(1'b1, OFS_PRIO_LO, 32'h30000209);
    per_cmd <= 30'h00004013;
    settle();
    vchk(7'h39, 2'h1, 19'h00100);
    apb(1'b0, OFS_PEND_PER, '0);
    chk("pend", 32'hFFFFFFEC, rd);
    per_cmd <= 30'h00004011;
    settle();
    vchk(7'h3C, 2'h1, 19'h00100);
    per_cmd <= 30'h00004000;
    settle();
    chk("valid", '0, 32'(core_vec.valid));
    apb(1'b1, OFS_VBASE, 32'h0007FFF0);
    apb(1'b1, OFS_PRIO_HI, 32'h0C000000);
    per_cmd <= 30'h20000000;
    settle();
    vchk(7'h55, 2'h2, 19'h7FFF0);
    per_cmd <= 30'h00000001;
    settle();
    vchk(7'h38, 2'h0, 19'h7FFF0);
    per_cmd <= '0;
  endtask

  task automatic t_slot;
    apb(1'b1, OFS_VBASE, {13'h0, RST_BASE});
    apb(1'b1, OFS_DBG_PRIO, 32'h00000010);
    dbg_cmd <= 3'h1;
    settle();
    chk("valid", '0, 32'(core_vec.valid));
    apb(1'b0, OFS_ISTAT, '0);
    chk("blocked", 32'h2, rd & 32'h2);
    apb(1'b1, OFS_DBG_PRIO, 32'h00000014);
    dbg_cmd <= 3'h3;
    settle();
    vchk(7'h02, 2'h1, RST_BASE);
    dbg_cmd <= '0;
    apb(1'b1, OFS_DBG_PRIO, '0);
  endtask

  task automatic t_irq;
    settle();
    apb(1'b1, OFS_ICLR, 32'h1);
    rchk(OFS_ISTAT, 32'h2);
    apb(1'b1, OFS_ICLR, 32'h2);
    rchk(OFS_ISTAT, '0);
    apb(1'b1, OFS_IEN, 32'h1);
    per_cmd <= 30'h1;
    settle();
    chk("irq", 32'h1, 32'(irq));
    apb(1'b1, OFS_IEN, 32'h0);
    settle();
    chk("irq", '0, 32'(irq));
    apb(1'b1, OFS_ICLR, 32'h1);
    rchk(OFS_ISTAT, '0);
    apb(1'b1, OFS_IEN, 32'h1);
    settle();
    chk("irq", '0, 32'(irq));
    apb(1'b0, 12'hFFC, '0);
    chk("pslverr", 32'h1, 32'(er));
    chk("prdata", '0, rd);
    per_cmd <= '0;
  endtask

  ////////////////////////////////////////
  task automatic stop_test;
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_dbg();
    t_per();
    t_slot();
    t_irq();
    stop_test();
  end
endmodule
